// ===== hw/pwd_pkg.sv
// Constants for the pulse and window watchdog
package pwd_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS       = 10000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS  = 1000000 / TICK_NS;
  // Times in ms
  localparam int RECONF_MS         = 250;
  localparam int SUPPLY_DISABLE_MS = 250;
  localparam int ANTI_LATCHUP_MS   = 10000;
  localparam int FAULT_PULSE_MS    = 2;
  // Nominal pulse spacing in 10 us units
  localparam logic [15:0] NOMINAL_PERIOD = 16'h00c8;
  localparam logic [15:0] SLOW_SCALE     = 16'h0004;
  // Register offsets
  localparam logic [4:0] ADDR_EDGE_VALID = 5'h05;
  localparam logic [4:0] ADDR_MIN_ADJ    = 5'h06;
  localparam logic [4:0] ADDR_MAX_ADJ    = 5'h07;
  localparam logic [4:0] ADDR_SELECT     = 5'h08;
  localparam logic [4:0] ADDR_LIMITS     = 5'h09;
  localparam logic [4:0] ADDR_OPTIONS    = 5'h0a;
  localparam logic [4:0] ADDR_STATUS     = 5'h0c;
  // Reset values
  localparam logic [7:0] EDGE_VALID_RST = 8'h40;
  localparam logic [7:0] MIN_ADJ_RST    = 8'h0c;
  localparam logic [7:0] MAX_ADJ_RST    = 8'h0c;
  localparam logic [7:0] SELECT_RST     = 8'h00;
  localparam logic [7:0] LIMITS_RST     = 8'h84;
  localparam logic [7:0] OPTIONS_RST    = 8'h00;
  // Field positions
  localparam int EDGE_SEL_LSB  = 0;
  localparam int VALID_LSB     = 4;
  localparam int FAST_LSB      = 0;
  localparam int SLOW_LSB      = 4;
  localparam int RST_ON_FLT_BIT = 0;
  localparam logic [1:0] SEL_WINDOW = 2'h1;
  // Edge counts
  localparam logic [3:0] EDGES_4  = 4'h4;
  localparam logic [3:0] EDGES_6  = 4'h6;
  localparam logic [3:0] EDGES_8  = 4'h8;
  localparam logic [3:0] EDGES_10 = 4'ha;

  typedef enum logic [3:0] {
    ST_IDLE, ST_TEST1, ST_TEST_INV, ST_TEST2, ST_ACTIVE,
    ST_PFAULT, ST_FLASH, ST_WIN_RUN, ST_WFAULT
  } wd_state_e;

  function automatic logic [3:0] edge_count_f(input logic [1:0] sel);
    unique case (sel)
      2'h0: edge_count_f = EDGES_4;
      2'h1: edge_count_f = EDGES_6;
      2'h2: edge_count_f = EDGES_8;
      2'h3: edge_count_f = EDGES_10;
    endcase
  endfunction : edge_count_f
endpackage : pwd_pkg

// ===== hw/pulse_window_watchdog.sv
// Pulse-period and window watchdog with its configuration registers
// Functional notes
// R1: After power-on reset rises, pulse mode runs; 250 ms to reconfigure.
// R2: Configuration writes are ignored once window mode is selected or the 250 ms reconfigure time ends.
// R3: Pulse fault: enable low now, CAN rail off 250 ms, logic enable 10 s.
// R4: Edge count finishing between min and max timers increments valid counter.
// R5: Pulse-ok at programmed valid count; enable needs ok, reset, 3.3 V, no error.
// R6: Early or late completion decrements valid counter; zero means pulse fault.
// R7: Too few edges by max timer: decrement, restart timers, next edge resyncs.
// R8: Min timer edges*(2+min adjust) ms, max timer edges*(2+max adjust) ms.
// R9: Edge count is 4, 6, 8 or 10, default 4.
// R10: Min adjust -0.08 to -0.15 ms in 0.01 steps, default -0.12; max 0.12.
// R11: Flash mode holds enable low only; secured restart leaves it.
// R12: Startup needs valid, invalid, then valid series before supply-disable time.
// R13: During startup test the fault status and fault flag stay inactive.
// R14: Second startup series uses half the valid count, full once active.
// R15: Missing second series at supply-disable time enters pulse fault mode.
// R16: After invalid pulses enable latched low, rail then logic enable removed.
// R17: Window select at 0x08, fast and slow limits at 0x09.
// R18: Window mode faults on too short or too long edge interval.
// R19: Window fault drops enable, optional 2 ms reset pulse, holds to restart.
// R20: Restart resumes previous configuration; power loss resets it.
// R21: Processor programs window registers and starts pulses before selecting.
// R22: Processor should drive valid pulses before issuing a restart.
// R23: Fault reset pulse lasts 2 ms.
// R24: Active-low fault flag goes low while a reportable fault exists.
// R25: Restart and flash arrive as one-cycle strobes; timers use system clock.
// R26: Restart clears fault, reloads valid counter, timers, pending timeouts.
module pulse_window_watchdog
  import pwd_pkg::*;
#(
  parameter int RECONF_TICKS   = RECONF_MS * TICKS_PER_MS,
  parameter int SUPPLY_TICKS   = SUPPLY_DISABLE_MS * TICKS_PER_MS,
  parameter int ANTI_TICKS     = ANTI_LATCHUP_MS * TICKS_PER_MS,
  parameter int FLT_PULSE_TICKS = FAULT_PULSE_MS * TICKS_PER_MS
)
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       arst_n_i,
  // Register port from the serial interface
  input  wire logic       reg_wr_i,
  input  wire logic [4:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Secured command strobes
  input  wire logic       restart_i,
  input  wire logic       flash_enter_i,
  // Supervised conditions
  input  wire logic       watchdog_pulse_input_i,
  input  wire logic       por_ok_i,
  input  wire logic       rail_3p3_en_i,
  input  wire logic       no_error_condition_i,
  // Outputs
  output logic            power_on_enable_o,
  output logic            power_on_reset_n_o,
  output logic            can_rail_en_o,
  output logic            logic_enable_pin_allow_o,
  output logic            fault_flag_n_o,
  output logic            watchdog_fault_status_o,
  output logic            pulse_ok_o
);

  localparam logic [20:0] SUPPLY_T = 21'(SUPPLY_TICKS);
  localparam logic [20:0] ANTI_T   = 21'(SUPPLY_TICKS + ANTI_TICKS);
  localparam logic [20:0] RECONF_T = 21'(RECONF_TICKS);
  localparam logic [20:0] FPULSE_T = 21'(FLT_PULSE_TICKS);
  localparam logic [10:0] TICK_T   = 11'(TICK_CYCLES - 1);

  wd_state_e   state_reg, state_next;
  logic [10:0] presc_reg;
  logic [20:0] reconf_reg, phase_reg, power_on_reset_n_cnt_reg;
  logic [15:0] timer_reg, win_timer_reg, tmin, tmax, tfast, tslow;
  logic [7:0]  edge_valid_reg, min_adj_reg, max_adj_reg, select_reg, limits_reg, options_reg;
  logic [3:0]  edge_cnt_reg, valid_cnt_reg, edge_count, valid_full, target;
  logic        tick, lock_reg, s1_reg, s2_reg, s3_reg, clean_reg, edge_q, resync_reg;
  logic        win_armed_reg, win_ok_reg, complete, good_ev, bad_ev, checking;
  logic        cfg_wr, win_sel_wr, win_fault, fault_now, ok_now, pfault_entry, wfault_entry;

  // 10 us time base from the system clock
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      presc_reg <= 11'h000;
    else if (tick)
      presc_reg <= 11'h000;
    else
      presc_reg <= presc_reg + 11'h001; // R25
  end
  assign tick = (presc_reg == TICK_T);

  // Pin synchroniser and qualified rising edge
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      {s1_reg, s2_reg, s3_reg, clean_reg} <= 4'h0;
    else
    begin
      {s3_reg, s2_reg, s1_reg} <= {s2_reg, s1_reg, watchdog_pulse_input_i};
      if (s2_reg == s3_reg)
        clean_reg <= s3_reg;
    end
  end
  assign edge_q = (s2_reg == s3_reg) && s3_reg && !clean_reg;

  // Configuration registers
  assign cfg_wr     = reg_wr_i && !lock_reg; // R2
  assign win_sel_wr = cfg_wr && (reg_addr_i == ADDR_SELECT)
                      && (reg_wdata_i[1:0] == SEL_WINDOW); // R17

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      edge_valid_reg <= EDGE_VALID_RST; // R9
      min_adj_reg    <= MIN_ADJ_RST; // R10
      max_adj_reg    <= MAX_ADJ_RST; // R10
      select_reg     <= SELECT_RST;
      limits_reg     <= LIMITS_RST;
      options_reg    <= OPTIONS_RST;
    end
    else if (cfg_wr)
    begin
      unique case (reg_addr_i)
        ADDR_EDGE_VALID: edge_valid_reg <= reg_wdata_i;
        ADDR_MIN_ADJ:    min_adj_reg    <= reg_wdata_i;
        ADDR_MAX_ADJ:    max_adj_reg    <= reg_wdata_i;
        ADDR_SELECT:     select_reg     <= reg_wdata_i; // R17
        ADDR_LIMITS:     limits_reg     <= reg_wdata_i; // R17
        ADDR_OPTIONS:    options_reg    <= reg_wdata_i;
        default:         ;
      endcase
    end
  end

  // Reconfiguration window and write lock
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reconf_reg <= 21'h000000;
      lock_reg   <= 1'b0;
    end
    else if (restart_i || state_reg == ST_IDLE)
    begin
      reconf_reg <= 21'h000000;
      lock_reg   <= 1'b0; // R20
    end
    else if (win_sel_wr || reconf_reg >= RECONF_T)
      lock_reg <= 1'b1; // R1
    else if (tick)
      reconf_reg <= reconf_reg + 21'h000001; // R1
  end

  // Timer limits in 10 us units
  assign edge_count = edge_count_f(edge_valid_reg[EDGE_SEL_LSB +: 2]); // R9
  assign tmin  = 16'(16'(edge_count) * (NOMINAL_PERIOD - 16'(min_adj_reg))); // R8
  assign tmax  = 16'(16'(edge_count) * (NOMINAL_PERIOD + 16'(max_adj_reg))); // R8
  assign tfast = 16'(16'(limits_reg[FAST_LSB +: 4]) * 16'(TICKS_PER_MS));
  assign tslow = 16'(16'(limits_reg[SLOW_LSB +: 4]) * SLOW_SCALE
                 * 16'(TICKS_PER_MS));
  assign valid_full = edge_valid_reg[VALID_LSB +: 4];
  assign target = (state_reg == ST_TEST2) ? (valid_full >> 1) : valid_full; // R14

  // Edge series qualification
  assign checking = (state_reg == ST_TEST1) || (state_reg == ST_TEST_INV)
                    || (state_reg == ST_TEST2) || (state_reg == ST_ACTIVE);
  assign complete = edge_q && !resync_reg && (edge_cnt_reg == edge_count - 4'h1);
  assign good_ev  = complete && (timer_reg >= tmin) && (timer_reg <= tmax); // R4
  assign bad_ev   = (complete && !good_ev) || (timer_reg > tmax); // R6 R7
  assign ok_now   = (target != 4'h0) && (valid_cnt_reg >= target); // R5
  assign fault_now = bad_ev && (valid_cnt_reg <= 4'h1); // R6

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      {edge_cnt_reg, timer_reg, resync_reg} <= 21'h000000;
    else if (!checking || restart_i)
      {edge_cnt_reg, timer_reg, resync_reg} <= 21'h000000; // R26
    else if (complete || timer_reg > tmax)
    begin
      edge_cnt_reg <= 4'h0; // R7
      timer_reg    <= 16'h0000;
      resync_reg   <= !complete;
    end
    else if (edge_q && resync_reg)
      {edge_cnt_reg, timer_reg, resync_reg} <= 21'h000000; // R7
    else
    begin
      if (edge_q)
        edge_cnt_reg <= edge_cnt_reg + 4'h1; // R4
      if (tick)
        timer_reg <= timer_reg + 16'h0001;
    end
  end

  // Valid counter
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      valid_cnt_reg <= 4'h0;
    else if (restart_i || (state_reg == ST_TEST2 && state_next == ST_ACTIVE))
      valid_cnt_reg <= valid_full; // R14 R26
    else if (state_reg == ST_TEST_INV && state_next == ST_TEST2)
      valid_cnt_reg <= 4'h0;
    else if (!checking)
      valid_cnt_reg <= 4'h0;
    else if (good_ev && valid_cnt_reg < valid_full)
      valid_cnt_reg <= valid_cnt_reg + 4'h1; // R4
    else if (bad_ev && valid_cnt_reg != 4'h0)
      valid_cnt_reg <= valid_cnt_reg - 4'h1; // R6
  end

  // Window interval measurement
  assign win_fault = (state_reg == ST_WIN_RUN) && win_armed_reg
                     && ((edge_q && win_timer_reg < tfast)
                         || win_timer_reg > tslow); // R18

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      {win_timer_reg, win_armed_reg, win_ok_reg} <= 18'h00000;
    else if (state_reg != ST_WIN_RUN || restart_i)
      {win_timer_reg, win_armed_reg, win_ok_reg} <= 18'h00000;
    else if (edge_q)
    begin
      win_timer_reg <= 16'h0000;
      win_armed_reg <= 1'b1;
      win_ok_reg    <= win_armed_reg && !win_fault;
    end
    else if (tick)
      win_timer_reg <= win_timer_reg + 16'h0001;
  end

  // Supervisor state machine
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (por_ok_i)
          state_next = ST_TEST1; // R1
      ST_TEST1:
        if (ok_now)
          state_next = ST_TEST_INV; // R12
      ST_TEST_INV:
        if (bad_ev)
          state_next = ST_TEST2; // R12
      ST_TEST2:
        if (ok_now)
          state_next = ST_ACTIVE; // R12
      ST_ACTIVE:
        if (fault_now)
          state_next = ST_PFAULT; // R6
      ST_PFAULT, ST_FLASH, ST_WIN_RUN, ST_WFAULT:
        ;
    endcase
    if ((state_reg == ST_TEST1 || state_reg == ST_TEST_INV
         || state_reg == ST_TEST2) && state_next != ST_ACTIVE
        && phase_reg >= SUPPLY_T)
      state_next = ST_PFAULT; // R15
    if (win_fault)
      state_next = ST_WFAULT; // R18 R19
    if (win_sel_wr && checking)
      state_next = ST_WIN_RUN; // R17
    if (flash_enter_i && state_reg != ST_IDLE)
      state_next = ST_FLASH; // R11
    if (restart_i && state_reg != ST_IDLE)
      state_next = (select_reg[1:0] == SEL_WINDOW) ? ST_WIN_RUN : ST_ACTIVE; // R11 R20 R26
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Startup and fault timeout timer
  assign pfault_entry = (state_next == ST_PFAULT) && (state_reg != ST_PFAULT);
  assign wfault_entry = (state_next == ST_WFAULT) && (state_reg != ST_WFAULT);

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      phase_reg <= 21'h000000;
    else if (pfault_entry || state_reg == ST_IDLE || restart_i)
      phase_reg <= 21'h000000; // R26
    else if (tick && phase_reg < ANTI_T)
      phase_reg <= phase_reg + 21'h000001; // R3 R16
  end

  // Fault-triggered reset pulse
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      power_on_reset_n_cnt_reg <= 21'h000000;
    else if (wfault_entry && options_reg[RST_ON_FLT_BIT])
      power_on_reset_n_cnt_reg <= FPULSE_T; // R19 R23
    else if (tick && power_on_reset_n_cnt_reg != 21'h000000)
      power_on_reset_n_cnt_reg <= power_on_reset_n_cnt_reg - 21'h000001; // R23
  end

  // Registered outputs
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      power_on_enable_o        <= 1'b0;
      power_on_reset_n_o       <= 1'b0;
      can_rail_en_o            <= 1'b1;
      logic_enable_pin_allow_o <= 1'b1;
      fault_flag_n_o           <= 1'b1;
      watchdog_fault_status_o  <= 1'b0;
      pulse_ok_o               <= 1'b0;
    end
    else
    begin
      pulse_ok_o <= (state_reg == ST_WIN_RUN) ? win_ok_reg
                    : (checking && ok_now); // R5
      power_on_enable_o <= ((state_reg == ST_ACTIVE && ok_now)
                            || (state_reg == ST_WIN_RUN && win_ok_reg))
                           && por_ok_i && rail_3p3_en_i
                           && no_error_condition_i; // R5 R11 R19
      power_on_reset_n_o <= por_ok_i && (power_on_reset_n_cnt_reg == 21'h000000); // R19
      can_rail_en_o <= !(state_reg == ST_PFAULT && phase_reg >= SUPPLY_T); // R3 R16
      logic_enable_pin_allow_o <= !(state_reg == ST_PFAULT
                                    && phase_reg >= ANTI_T); // R3 R16
      watchdog_fault_status_o <= (state_reg == ST_PFAULT)
                                 || (state_reg == ST_WFAULT); // R13
      fault_flag_n_o <= !((state_reg == ST_PFAULT)
                          || (state_reg == ST_WFAULT)); // R13 R24
    end
  end

  // Register read data
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= 8'h00;
    else
    begin
      unique case (reg_addr_i)
        ADDR_EDGE_VALID: reg_rdata_o <= edge_valid_reg;
        ADDR_MIN_ADJ:    reg_rdata_o <= min_adj_reg;
        ADDR_MAX_ADJ:    reg_rdata_o <= max_adj_reg;
        ADDR_SELECT:     reg_rdata_o <= select_reg;
        ADDR_LIMITS:     reg_rdata_o <= limits_reg;
        ADDR_OPTIONS:    reg_rdata_o <= options_reg;
        ADDR_STATUS:     reg_rdata_o <= {lock_reg, pulse_ok_o, can_rail_en_o, logic_enable_pin_allow_o,
                                         watchdog_fault_status_o, state_reg == ST_FLASH,
                                         state_reg == ST_WIN_RUN, state_reg == ST_ACTIVE};
        default:         reg_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule : pulse_window_watchdog

// ===== verification/pulse_window_watchdog_chk.sv
// Port assertions for the pulse and window watchdog
module pulse_window_watchdog_chk
  import pwd_pkg::*;
#(
  parameter int FLT_PULSE_TICKS = 200
)
(
  // Watched ports
  input wire logic       mclk_i,
  input wire logic       arst_n_i,
  input wire logic       reg_wr_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       restart_i,
  input wire logic       flash_enter_i,
  input wire logic       watchdog_pulse_input_i,
  input wire logic       por_ok_i,
  input wire logic       rail_3p3_en_i,
  input wire logic       no_error_condition_i,
  input wire logic       power_on_enable_o,
  input wire logic       power_on_reset_n_o,
  input wire logic       can_rail_en_o,
  input wire logic       logic_enable_pin_allow_o,
  input wire logic       fault_flag_n_o,
  input wire logic       watchdog_fault_status_o,
  input wire logic       pulse_ok_o
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int PULSE_CYC = FLT_PULSE_TICKS * TICK_CYCLES;
  int low_cnt_reg;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Length of the current low phase of the reset output
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      low_cnt_reg <= 0;
    else if (power_on_reset_n_o)
      low_cnt_reg <= 0;
    else
      low_cnt_reg <= low_cnt_reg + 1;
  end

  en_needs_cond_a: assert property (!(por_ok_i && rail_3p3_en_i && no_error_condition_i) |=> !power_on_enable_o)
    else $error("enable high without its conditions");
  flag_status_a: assert property (watchdog_fault_status_o |-> !fault_flag_n_o)
    else $error("fault status without fault flag");
  fault_drops_en_a: assert property (!fault_flag_n_o |-> !power_on_enable_o)
    else $error("enable high during a fault");
  can_enable_a: assert property (!can_rail_en_o |-> !power_on_enable_o)
    else $error("enable high with CAN rail off");
  rail_order_a: assert property ($fell(logic_enable_pin_allow_o) |-> !$past(can_rail_en_o, 8))
    else $error("logic enable removed before CAN rail");
  restart_clears_a: assert property (restart_i |-> ##2 fault_flag_n_o && can_rail_en_o
    && logic_enable_pin_allow_o)
    else $error("restart did not clear fault state");
  flash_rails_a: assert property (flash_enter_i && !restart_i && can_rail_en_o && logic_enable_pin_allow_o
    |-> ##2 (!power_on_enable_o && can_rail_en_o && logic_enable_pin_allow_o) [*3])
    else $error("flash mode touched rails or enable");
  por_follows_a: assert property (!por_ok_i |=> !power_on_reset_n_o)
    else $error("reset output high while reset condition low");
  fault_pulse_len_a: assert property ($rose(power_on_reset_n_o) && low_cnt_reg > 8
    |-> low_cnt_reg >= PULSE_CYC - TICK_CYCLES && low_cnt_reg <= PULSE_CYC + TICK_CYCLES)
    else $error("fault reset pulse length wrong");

  restart_c: cover property (restart_i);
  flash_c: cover property (flash_enter_i);
  can_off_c: cover property ($fell(can_rail_en_o));
  pulse_c: cover property ($rose(power_on_reset_n_o) && low_cnt_reg > 8);
endmodule : pulse_window_watchdog_chk

bind pulse_window_watchdog pulse_window_watchdog_chk #(.FLT_PULSE_TICKS(FLT_PULSE_TICKS)) chk_u (
  .mclk_i, .arst_n_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .restart_i, .flash_enter_i,
  .watchdog_pulse_input_i, .por_ok_i, .rail_3p3_en_i, .no_error_condition_i, .power_on_enable_o,
  .power_on_reset_n_o, .can_rail_en_o, .logic_enable_pin_allow_o, .fault_flag_n_o,
  .watchdog_fault_status_o, .pulse_ok_o
);

// ===== verification/pulse_host_model.sv
// Host processor model driving the watchdog pulse pin
module pulse_host_model
(
  // Clock
  input  wire logic mclk_i,
  // Pulse pin
  output logic      pulse_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial pulse_o = 1'b0;

  // Rising edge after gap cycles, short high phase, pin driven low between
  task automatic send(input int n, input int gap);
    repeat (n)
    begin
      repeat (gap) @(negedge mclk_i);
      pulse_o = 1'b1;
      repeat (4) @(negedge mclk_i);
      pulse_o = 1'b0;
    end
  endtask : send
endmodule : pulse_host_model

// ===== verification/pulse_window_watchdog_test.sv
// Testbench for the pulse and window watchdog
module pulse_window_watchdog_test
  import pwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int RECONF = 4;
  localparam int SUPPLY = 8;
  localparam int ANTI   = 6;
  localparam int FLT    = 2;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] rst;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_s;

  logic       mclk_i, arst_n_i, reg_wr_i, restart_i, flash_enter_i, wd_pin;
  logic       por_ok_i, rail_3p3_en_i, no_error_condition_i;
  logic [4:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic       power_on_enable_o, power_on_reset_n_o, can_rail_en_o, logic_enable_pin_allow_o;
  logic       fault_flag_n_o, watchdog_fault_status_o, pulse_ok_o;
  int         failures, n_compared;
  row_s       rows [7] = '{'{5'h05, 8'h40, 8'h43, 8'h43}, '{5'h06, 8'h0c, 8'h0f, 8'h0f},
                           '{5'h07, 8'h0c, 8'h10, 8'h10}, '{5'h09, 8'h84, 8'h81, 8'h81},
                           '{5'h0a, 8'h00, 8'h01, 8'h01}, '{5'h08, 8'h00, 8'h00, 8'h00},
                           '{5'h0c, 8'h30, 8'hff, 8'h30}};

  pulse_window_watchdog #(.RECONF_TICKS(RECONF), .SUPPLY_TICKS(SUPPLY), .ANTI_TICKS(ANTI),
    .FLT_PULSE_TICKS(FLT)) dut_u (
    .mclk_i, .arst_n_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .restart_i, .flash_enter_i,
    .watchdog_pulse_input_i(wd_pin), .por_ok_i, .rail_3p3_en_i, .no_error_condition_i, .power_on_enable_o,
    .power_on_reset_n_o, .can_rail_en_o, .logic_enable_pin_allow_o, .fault_flag_n_o,
    .watchdog_fault_status_o, .pulse_ok_o
  );

  pulse_host_model host_u (.mclk_i(mclk_i), .pulse_o(wd_pin));

  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  function automatic logic [7:0] outs();
    return {power_on_enable_o, power_on_reset_n_o, can_rail_en_o, logic_enable_pin_allow_o,
            fault_flag_n_o, watchdog_fault_status_o, pulse_ok_o, 1'b0};
  endfunction : outs

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_i = a;
    repeat (2) @(negedge mclk_i);
    d = reg_rdata_o;
  endtask : rd

  // One-cycle secured command, returns once its outputs have landed
  task automatic cmd(input logic rst);
    @(negedge mclk_i);
    restart_i     = rst;
    flash_enter_i = !rst;
    @(negedge mclk_i);
    restart_i     = 1'b0;
    flash_enter_i = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask : cmd

  task automatic wait_bit(input int b, input logic v, input int lim, output int n);
    logic [7:0] o;
    n = 0;
    o = outs();
    while (o[b] !== v && n < lim)
    begin
      @(negedge mclk_i);
      n++;
      o = outs();
    end
    chk("wait_bit", {7'h0, o[b]}, {7'h0, v});
  endtask : wait_bit

  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (80000) @(posedge mclk_i);
    failures++;
    test_done();
  end

  initial
  begin
    logic [7:0] d;
    int         n;
    {arst_n_i, reg_wr_i, restart_i, flash_enter_i} = 4'h0;
    {por_ok_i, rail_3p3_en_i, no_error_condition_i} = 3'h7;
    reg_addr_i  = 5'h00;
    reg_wdata_i = 8'h00;
    repeat (4) @(negedge mclk_i);
    chk("reset_outs", outs(), 8'h38);
    chk("reset_rdata", reg_rdata_o, 8'h00);
    repeat (4) @(negedge mclk_i);
    arst_n_i = 1'b1;
    foreach (rows[i])
    begin
      rd(rows[i].addr, d);
      chk("reg_reset", d, rows[i].rst);
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d);
      chk("reg_write", d, rows[i].exp);
    end
    // Startup test without pulses runs into the supply-disable timeout
    repeat ((RECONF + 1) * TICK_CYCLES) @(negedge mclk_i);
    wr(5'h06, 8'h20);
    rd(5'h06, d);
    chk("locked_write", d, 8'h0f);
    chk("test_state", outs(), 8'h78);
    wait_bit(5, 1'b0, 2 * SUPPLY * TICK_CYCLES, n);
    chk("can_delay", {7'h0, n >= (SUPPLY - RECONF - 2) * TICK_CYCLES}, 8'h01);
    chk("pfault", outs(), 8'h54);
    wait_bit(4, 1'b0, (ANTI + 2) * TICK_CYCLES, n);
    chk("allow_delay", {7'h0, n >= (ANTI - 1) * TICK_CYCLES}, 8'h01);
    chk("allow_off", outs(), 8'h44);
    cmd(1'b1);
    d = outs();
    chk("restart", d, 8'hfa);
    chk("enable_vs_ok", {7'h0, d[7]}, {7'h0, d[1]});
    for (int i = 0; i < 2; i++)
    begin
      @(negedge mclk_i);
      {rail_3p3_en_i, no_error_condition_i} = i[0] ? 2'b10 : 2'b01;
      repeat (2) @(negedge mclk_i);
      chk("enable_cond", outs() & 8'h80, 8'h00);
      {rail_3p3_en_i, no_error_condition_i} = 2'b11;
    end
    // Window mode with a too short interval
    host_u.send(1, 10);
    wr(5'h08, 8'h01);
    wr(5'h09, 8'h22);
    rd(5'h09, d);
    chk("locked_limits", d, 8'h81);
    rd(5'h0c, d);
    chk("window_status", d & 8'hbf, 8'hb2);
    host_u.send(2, 4000);
    wait_bit(6, 1'b0, 20, n);
    wait_bit(6, 1'b1, (FLT + 2) * TICK_CYCLES, n);
    chk("reset_pulse_len", {7'h0, n >= (FLT - 1) * TICK_CYCLES}, 8'h01);
    chk("window_fault", outs() & 8'hbc, 8'h34);
    host_u.send(1, 10);
    cmd(1'b1);
    chk("win_restart", outs(), 8'h78);
    cmd(1'b0);
    chk("flash", outs() & 8'hb0, 8'h30);
    repeat (TICK_CYCLES) @(negedge mclk_i);
    chk("flash_hold", outs() & 8'hb0, 8'h30);
    cmd(1'b1);
    por_ok_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk("por_low", outs() & 8'h40, 8'h00);
    por_ok_i = 1'b1;
    // Power loss returns the configuration to defaults
    arst_n_i = 1'b0;
    repeat (8) @(negedge mclk_i);
    arst_n_i = 1'b1;
    rd(5'h09, d);
    chk("limits_after_loss", d, 8'h84);
    rd(5'h08, d);
    chk("select_after_loss", d, 8'h00);
    test_done();
  end
endmodule : pulse_window_watchdog_test
